//--- core/hbfm_top.v
// Half-bridge fault supervision, mode control and AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "hbfm_regs.vh"
module hbfm_top #(
    parameter NCH = 7,
    parameter CW = 16
) (
    input wire aclk, // Clock, 100 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire wake_reset_n, // Wake / reset pin
    input wire external_failsafe_in, // External failsafe pin
    input wire spi_fault, // Serial communication fault
    input wire global_fault_in, // Device global fault present
    input wire [NCH-1:0] drive_high_sel, // Per channel: high side on, else low
    input wire [NCH-1:0] vds_high_cmp, // High-side overload comparators
    input wire [NCH-1:0] vds_low_cmp, // Low-side overload comparators
    input wire [7:0] node_cmp, // Switch-node comparators
    output reg [NCH-1:0] high_gate_out, // High-side gate enables
    output reg [NCH-1:0] low_gate_out, // Low-side gate enables
    output reg [2:0] high_test_current_en, // High-side test currents, odd nodes
    output reg [2:0] low_test_current_en, // Low-side test currents, odd nodes
    output reg [NCH-1:0] hs_active_pulldown_en, // High-side active pull-downs
    output reg switched_pump_out, // Switched pump output
    output reg charge_pump_en, // Charge pump enable
    output reg [3*NCH-1:0] vds_threshold_out, // Thresholds to comparators
    output reg [1:0] mode_out // Operating mode
);
    localparam NS = 4 + 3 * NCH + 8;
    localparam [CW-1:0] STEP_CYC = `HBFM_DLY_STEP_CYC;
    localparam [CW-1:0] DGL_CYC = `HBFM_DGL_CYC;
    // Pin synchronisers
    reg [NS-1:0] sync_a_reg;
    reg [NS-1:0] sync_b_reg;
    wire [NS-1:0] pins_in = {node_cmp, vds_low_cmp, vds_high_cmp, drive_high_sel,
                             global_fault_in, spi_fault, external_failsafe_in, wake_reset_n};
    wire wake_s = sync_b_reg[0];
    wire efs_s = sync_b_reg[1];
    wire spi_fault_s = sync_b_reg[2];
    wire gflt_s = sync_b_reg[3];
    wire [NCH-1:0] dir_s = sync_b_reg[4 +: NCH];
    wire [NCH-1:0] cmph_s = sync_b_reg[4 + NCH +: NCH];
    wire [NCH-1:0] cmpl_s = sync_b_reg[4 + 2 * NCH +: NCH];
    wire [7:0] node_s = sync_b_reg[4 + 3 * NCH +: 8];
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_reg <= {NS{1'b0}};
            sync_b_reg <= {NS{1'b0}};
        end else begin
            sync_a_reg <= pins_in;
            sync_b_reg <= sync_a_reg;
        end
    end
    // Mode state machine
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg wake_prev_reg;
    reg enter_normal;
    reg wd_toggle;
    wire is_normal = (mode_reg == `HBFM_MODE_NORMAL);
    wire fail_req = efs_s | spi_fault_s;
    always @* begin
        mode_next = mode_reg;
        enter_normal = 1'b0;
        case (mode_reg)
            `HBFM_MODE_SLEEP: begin
                if (wake_s && !wake_prev_reg) begin
                    mode_next = `HBFM_MODE_NORMAL;
                    enter_normal = 1'b1;
                end
            end
            `HBFM_MODE_NORMAL: begin
                if (!wake_s) begin
                    mode_next = `HBFM_MODE_SLEEP;
                end else if (fail_req) begin
                    mode_next = `HBFM_MODE_FAILSAFE;
                end
            end
            `HBFM_MODE_FAILSAFE: begin
                if (!wake_s) begin
                    mode_next = `HBFM_MODE_SLEEP;
                end else if (wd_toggle && !efs_s && !spi_fault_s) begin
                    mode_next = `HBFM_MODE_NORMAL;
                    enter_normal = 1'b1;
                end
            end
            default: begin
                mode_next = `HBFM_MODE_SLEEP;
            end
        endcase
    end
    // Register storage
    reg [6:0] en_reg;
    reg diag_mode_reg;
    reg [2:0] diag_sel_reg;
    reg wd_reg;
    reg [5:0] diag_reg;
    reg [7*NCH-1:0] cfg_reg;
    reg rcf_reg;
    reg qfs_reg;
    reg [NCH-1:0] ovl_h_reg;
    reg [NCH-1:0] ovl_l_reg;
    wire clear_regs = enter_normal || (mode_reg == `HBFM_MODE_SLEEP);
    // AXI4-Lite write path
    reg aw_full_reg;
    reg w_full_reg;
    reg [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    wire [31:0] bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [31:0] wmain = ({20'h00000, wd_reg, diag_sel_reg, diag_mode_reg, en_reg} & ~bmask)
                        | (wdata_reg & bmask);
    wire wr_main = wr_fire && (awaddr_reg == `HBFM_OFF_MAIN_CTRL);
    wire wr_diag = wr_fire && (awaddr_reg == `HBFM_OFF_DIAG_CTRL);
    wire wr_cfg = wr_fire && (awaddr_reg >= `HBFM_OFF_CFG_B0)
                  && (awaddr_reg <= `HBFM_OFF_CFG_B6) && (awaddr_reg[1:0] == 2'h0);
    wire [7:0] cfg_rel = awaddr_reg - `HBFM_OFF_CFG_B0;
    wire [2:0] cfg_idx = cfg_rel[4:2];
    // Failsafe takes only the main control word; sleep takes nothing
    wire wr_ok = is_normal ? (wr_main | wr_diag | wr_cfg)
               : ((mode_reg == `HBFM_MODE_FAILSAFE) & wr_main);
    always @* begin
        wd_toggle = wr_main && (mode_reg == `HBFM_MODE_FAILSAFE)
                    && (wmain[`HBFM_MC_WD_BIT] != wd_reg);
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HBFM_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
            s_axi_awready <= ~((aw_full_reg & ~wr_fire) | aw_take);
            s_axi_wready <= ~((w_full_reg & ~wr_fire) | w_take);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `HBFM_RESP_OKAY : `HBFM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // AXI4-Lite read path, clear-on-read side effects
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_awake = (mode_reg != `HBFM_MODE_SLEEP);
    wire rd_dev = ar_take && rd_awake && (s_axi_araddr == `HBFM_OFF_DEV_STAT);
    wire rd_ovla = ar_take && rd_awake && (s_axi_araddr == `HBFM_OFF_OVL_A);
    wire rd_ovlb = ar_take && rd_awake && (s_axi_araddr == `HBFM_OFF_OVL_B);
    wire [7:0] ar_rel = s_axi_araddr - `HBFM_OFF_CFG_B0;
    wire ar_cfg = (s_axi_araddr >= `HBFM_OFF_CFG_B0) && (s_axi_araddr <= `HBFM_OFF_CFG_B6)
                  && (s_axi_araddr[1:0] == 2'h0);
    wire [NCH-1:0] clr_grp = {rd_ovlb, {(NCH-1){rd_ovla}}};
    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `HBFM_OFF_MAIN_CTRL: rd_mux = {20'h00000, wd_reg, diag_sel_reg, diag_mode_reg,
                                           en_reg};
            `HBFM_OFF_DIAG_CTRL: rd_mux = {26'h0000000, diag_reg};
            `HBFM_OFF_DEV_STAT: rd_mux = {28'h0000000, mode_reg, qfs_reg, rcf_reg};
            `HBFM_OFF_OVL_A: rd_mux = {20'h00000, ovl_l_reg[5:0], ovl_h_reg[5:0]};
            `HBFM_OFF_OVL_B: rd_mux = {30'h00000000, ovl_l_reg[6], ovl_h_reg[6]};
            `HBFM_OFF_NODE_STAT: rd_mux = {24'h000000, node_s};
            default: begin
                if (ar_cfg) begin
                    rd_mux = {25'h0000000, cfg_reg[7 * ar_rel[4:2] +: 7]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HBFM_RESP_OKAY;
        end else begin
            s_axi_arready <= ~((s_axi_rvalid & ~s_axi_rready) | ar_take);
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_mux : 32'h00000000;
                s_axi_rresp <= rd_hit ? `HBFM_RESP_OKAY : `HBFM_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // Overload channels
    wire [NCH-1:0] trip_h;
    wire [NCH-1:0] trip_l;
    wire [NCH-1:0] trip_any = (trip_h | trip_l) & {NCH{is_normal}};
    wire [NCH-1:0] faulted = ovl_h_reg | ovl_l_reg;
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            wire [3:0] dsel = cfg_reg[7 * gi + `HBFM_CFG_DLY_LSB +: 4];
            wire [CW-1:0] dcyc = ({{(CW-4){1'b0}}, dsel} + {{(CW-1){1'b0}}, 1'b1}) * STEP_CYC;
            hbfm_channel #(
                .CW(CW)
            ) u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .on_high(high_gate_out[gi]),
                .on_low(low_gate_out[gi]),
                .cmp_high(cmph_s[gi]),
                .cmp_low(cmpl_s[gi]),
                .delay_cyc(dcyc),
                .dgl_cyc(DGL_CYC),
                .trip_high(trip_h[gi]),
                .trip_low(trip_l[gi])
            );
        end
    endgenerate
    // Control, status and outputs
    integer ci;
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= `HBFM_MODE_SLEEP;
            wake_prev_reg <= 1'b1;
            en_reg <= 7'h00;
            diag_mode_reg <= 1'b0;
            diag_sel_reg <= 3'h0;
            wd_reg <= 1'b0;
            diag_reg <= `HBFM_RST_DIAG_CTRL;
            cfg_reg <= {NCH{`HBFM_RST_CFG}};
            rcf_reg <= 1'b0;
            qfs_reg <= 1'b0;
            ovl_h_reg <= {NCH{1'b0}};
            ovl_l_reg <= {NCH{1'b0}};
            high_gate_out <= {NCH{1'b0}};
            low_gate_out <= {NCH{1'b0}};
            high_test_current_en <= 3'h0;
            low_test_current_en <= 3'h0;
            hs_active_pulldown_en <= {NCH{1'b0}};
            switched_pump_out <= 1'b0;
            charge_pump_en <= 1'b0;
            vds_threshold_out <= {3 * NCH{1'b0}};
            mode_out <= `HBFM_MODE_SLEEP;
        end else begin
            mode_reg <= mode_next;
            mode_out <= mode_next;
            wake_prev_reg <= wake_s;
            if (clear_regs) begin
                en_reg <= 7'h00;
                diag_mode_reg <= 1'b0;
                diag_sel_reg <= 3'h0;
                wd_reg <= 1'b0;
                diag_reg <= `HBFM_RST_DIAG_CTRL;
                cfg_reg <= {NCH{`HBFM_RST_CFG}};
                ovl_h_reg <= {NCH{1'b0}};
                ovl_l_reg <= {NCH{1'b0}};
                qfs_reg <= 1'b0;
                rcf_reg <= enter_normal;
            end else begin
                if (wr_ok && wr_main) begin
                    if (is_normal) begin
                        en_reg <= wmain[6:0] & ~faulted & ~trip_any;
                    end
                    diag_mode_reg <= wmain[`HBFM_MC_DIAGMODE_BIT];
                    diag_sel_reg <= wmain[`HBFM_MC_DIAGSEL_LSB +: 3];
                    wd_reg <= wmain[`HBFM_MC_WD_BIT];
                end else begin
                    en_reg <= en_reg & ~trip_any;
                end
                if (wr_ok && wr_diag) begin
                    diag_reg <= (diag_reg & ~bmask[5:0]) | (wdata_reg[5:0] & bmask[5:0]);
                end
                for (ci = 0; ci < NCH; ci = ci + 1) begin
                    if (wr_ok && wr_cfg && (cfg_idx == ci)) begin
                        cfg_reg[7 * ci +: 7] <= (cfg_reg[7 * ci +: 7] & ~bmask[6:0])
                                                | (wdata_reg[6:0] & bmask[6:0]);
                    end
                end
                // Hardware set wins over read clear
                ovl_h_reg <= (ovl_h_reg & ~clr_grp) | (trip_h & {NCH{is_normal}});
                ovl_l_reg <= (ovl_l_reg & ~clr_grp) | (trip_l & {NCH{is_normal}});
                qfs_reg <= (qfs_reg & ~rd_dev) | (|trip_any);
                rcf_reg <= rcf_reg & ~rd_dev;
            end
            high_gate_out <= {NCH{mode_next == `HBFM_MODE_NORMAL}} & en_reg & dir_s
                             & ~trip_any & ~faulted;
            low_gate_out <= {NCH{mode_next == `HBFM_MODE_NORMAL}} & en_reg & ~dir_s
                            & ~trip_any & ~faulted;
            // Test currents, independent of each other
            if ((mode_next == `HBFM_MODE_NORMAL) && !gflt_s && !clear_regs) begin
                high_test_current_en <= diag_reg[2:0];
                low_test_current_en <= diag_reg[5:3];
                hs_active_pulldown_en <= {NCH{~(|diag_reg)}};
            end else begin
                high_test_current_en <= 3'h0;
                low_test_current_en <= 3'h0;
                hs_active_pulldown_en <= {NCH{mode_next == `HBFM_MODE_NORMAL}};
            end
            switched_pump_out <= (mode_next == `HBFM_MODE_NORMAL);
            charge_pump_en <= (mode_next == `HBFM_MODE_NORMAL);
            for (ci = 0; ci < NCH; ci = ci + 1) begin
                vds_threshold_out[3 * ci +: 3] <= cfg_reg[7 * ci + `HBFM_CFG_VDS_LSB +: 3];
            end
        end
    end
endmodule

//--- core/hbfm_regs.vh
// Register map, field positions, reset values and timing counts
`ifndef HBFM_REGS_VH
`define HBFM_REGS_VH
`define HBFM_ADDR_W 8
`define HBFM_OFF_MAIN_CTRL 8'h00
`define HBFM_OFF_DIAG_CTRL 8'h04
`define HBFM_OFF_CFG_B0 8'h08
`define HBFM_OFF_CFG_B6 8'h20
`define HBFM_OFF_DEV_STAT 8'h24
`define HBFM_OFF_OVL_A 8'h28
`define HBFM_OFF_OVL_B 8'h2c
`define HBFM_OFF_NODE_STAT 8'h30
`define HBFM_MC_EN_LSB 0
`define HBFM_MC_DIAGMODE_BIT 7
`define HBFM_MC_DIAGSEL_LSB 8
`define HBFM_MC_WD_BIT 11
`define HBFM_CFG_VDS_LSB 0
`define HBFM_CFG_DLY_LSB 3
`define HBFM_DS_RCF_BIT 0
`define HBFM_DS_QFS_BIT 1
`define HBFM_DS_MODE_LSB 2
`define HBFM_OVLA_LOW_LSB 6
`define HBFM_RST_MAIN_CTRL 12'h000
`define HBFM_RST_DIAG_CTRL 6'h00
`define HBFM_RST_CFG 7'h00
`define HBFM_MODE_SLEEP 2'h0
`define HBFM_MODE_NORMAL 2'h1
`define HBFM_MODE_FAILSAFE 2'h2
`define HBFM_RESP_OKAY 2'h0
`define HBFM_RESP_SLVERR 2'h2
`define HBFM_CLK_MHZ 100
`define HBFM_DLY_STEP_NS 500
`define HBFM_DGL_NS 2000
`define HBFM_DLY_STEP_CYC ((`HBFM_DLY_STEP_NS * `HBFM_CLK_MHZ + 999) / 1000)
`define HBFM_DGL_CYC ((`HBFM_DGL_NS * `HBFM_CLK_MHZ + 999) / 1000)
`endif

//--- core/hbfm_channel.v
// Per half-bridge overload timer: detect delay, deglitch, trip pulses
`timescale 1ns/1ns
module hbfm_channel #(
    parameter CW = 16
) (
    input wire aclk, // Clock
    input wire aresetn, // Synchronous reset, active low
    input wire on_high, // High-side gate commanded on
    input wire on_low, // Low-side gate commanded on
    input wire cmp_high, // High-side drain-source comparator
    input wire cmp_low, // Low-side drain-source comparator
    input wire [CW-1:0] delay_cyc, // Detect delay in cycles
    input wire [CW-1:0] dgl_cyc, // Deglitch length in cycles
    output reg trip_high, // One-cycle trip, high side
    output reg trip_low // One-cycle trip, low side
);
    reg prev_high_reg;
    reg prev_low_reg;
    reg [CW-1:0] dly_cnt_reg;
    reg [CW-1:0] dgl_cnt_reg;
    wire turn_on = (on_high & ~prev_high_reg) | (on_low & ~prev_low_reg);
    wire expired = (dly_cnt_reg >= delay_cyc);
    wire cmp_act = (on_high & cmp_high) | (on_low & cmp_low);
    wire fire = expired & cmp_act & (dgl_cnt_reg == dgl_cyc - {{(CW-1){1'b0}}, 1'b1});

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_high_reg <= 1'b0;
            prev_low_reg <= 1'b0;
            dly_cnt_reg <= {CW{1'b0}};
            dgl_cnt_reg <= {CW{1'b0}};
            trip_high <= 1'b0;
            trip_low <= 1'b0;
        end else begin
            prev_high_reg <= on_high;
            prev_low_reg <= on_low;
            // Delay restarts at each turn-on
            if (turn_on || !(on_high || on_low)) begin
                dly_cnt_reg <= {CW{1'b0}};
            end else if (!expired) begin
                dly_cnt_reg <= dly_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
            // Deglitch runs only after the delay
            if (turn_on || !expired || !cmp_act || fire) begin
                dgl_cnt_reg <= {CW{1'b0}};
            end else begin
                dgl_cnt_reg <= dgl_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
            trip_high <= fire & on_high & cmp_high;
            trip_low <= fire & on_low & cmp_low;
        end
    end
endmodule

//--- verif/hbfm_monitor.sv
// Port-level checks on the supervision block
`timescale 1ns/1ns
module hbfm_monitor #(
    parameter NCH = 7,
    parameter CW = 16
) (
    input wire aclk, // Clock
    input wire aresetn, // Sync reset, low
    input wire wake_reset_n, // Wake pin
    input wire external_failsafe_in, // Failsafe pin
    input wire [NCH-1:0] vds_high_cmp, // High comparators
    input wire [NCH-1:0] high_gate_out, // High gates
    input wire [NCH-1:0] low_gate_out, // Low gates
    input wire [2:0] high_test_current_en, // High tests
    input wire [2:0] low_test_current_en, // Low tests
    input wire [NCH-1:0] hs_active_pulldown_en, // Pull-downs
    input wire switched_pump_out, // Pump out
    input wire charge_pump_en, // Charge pump
    input wire [1:0] mode_out // Mode
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    localparam int TRIP_MAX = 1020;
    logic [10:0] ovl_cnt;
    wire tst = |{high_test_current_en, low_test_current_en};
    wire gates = |{high_gate_out, low_gate_out};
    // Cycles ch0 stays on against an overload
    always @(posedge aclk) begin
        if (!aresetn || !high_gate_out[0] || !vds_high_cmp[0]) begin
            ovl_cnt <= 11'h000;
        end else if (ovl_cnt != 11'h7ff) begin
            ovl_cnt <= ovl_cnt + 11'h001;
        end
    end
    sequence wake_gone;
        !wake_reset_n [*5];
    endsequence
    sequence fs_held;
        (wake_reset_n && external_failsafe_in && mode_out != 2'h0) [*5];
    endsequence
    sleep_quiet_a: assert property (mode_out == 2'h0 |-> !gates && !tst)
        else $error("outputs active in sleep");
    fs_quiet_a: assert property (mode_out == 2'h2 |-> !gates && !tst && !charge_pump_en)
        else $error("outputs active in failsafe");
    pump_normal_a: assert property (switched_pump_out |-> mode_out == 2'h1)
        else $error("pump on outside normal");
    pulldown_off_a: assert property (tst |-> hs_active_pulldown_en == '0)
        else $error("pull-down on with test current");
    test_normal_a: assert property (tst |-> mode_out == 2'h1)
        else $error("test current outside normal");
    wake_sleep_a: assert property (wake_gone |-> mode_out == 2'h0)
        else $error("no sleep after wake low");
    fs_entry_a: assert property (fs_held |-> mode_out == 2'h2)
        else $error("no failsafe entry");
    ovl_trip_a: assert property (ovl_cnt <= TRIP_MAX)
        else $error("overload not latched off");
endmodule
bind hbfm_top hbfm_monitor #(.NCH(NCH), .CW(CW)) u_mon (.aclk(aclk), .aresetn(aresetn),
    .wake_reset_n(wake_reset_n), .external_failsafe_in(external_failsafe_in),
    .vds_high_cmp(vds_high_cmp), .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
    .high_test_current_en(high_test_current_en), .low_test_current_en(low_test_current_en),
    .hs_active_pulldown_en(hs_active_pulldown_en), .switched_pump_out(switched_pump_out),
    .charge_pump_en(charge_pump_en), .mode_out(mode_out));

//--- verif/hbfm_mcu_model.sv
// Supervising controller pins: wake, failsafe, serial fault
`timescale 1ns/1ns
module hbfm_mcu_model (
    input wire aclk, // Clock
    output logic wake_reset_n, // Wake pin
    output logic external_failsafe_in, // Failsafe pin
    output logic spi_fault // Serial fault
);
    initial begin
        wake_reset_n = 1'b0;
        external_failsafe_in = 1'b0;
        spi_fault = 1'b0;
    end
    task automatic wake();
        wake_reset_n <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask
    task automatic sleep();
        wake_reset_n <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
    task automatic fault(input logic ext, input logic spi);
        external_failsafe_in <= ext;
        spi_fault <= spi;
        repeat (6) @(posedge aclk);
    endtask
endmodule

//--- verif/hbfm_top_tb_top.sv
// Bench for the half-bridge supervision block
`timescale 1ns/1ns
`include "hbfm_regs.vh"
module hbfm_top_tb_top;
    logic aclk, aresetn, awvalid, wvalid, arvalid, gflt;
    logic [7:0] awaddr, araddr, ncmp;
    logic [31:0] wdata;
    logic [6:0] dsel, hcmp, lcmp;
    wire awready, wready, bvalid, arready, rvalid, wake, fsi, sft, pump, cpen;
    wire [1:0] bresp, rresp, mode;
    wire [31:0] rdata;
    wire [6:0] hg, lg, pd;
    wire [2:0] ht, lt;
    wire [20:0] thr;
    int n_mismatch = 0;
    int n_tests = 0;
    hbfm_mcu_model u_mcu (.aclk(aclk), .wake_reset_n(wake), .external_failsafe_in(fsi),
        .spi_fault(sft));
    hbfm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .wake_reset_n(wake),
        .external_failsafe_in(fsi), .spi_fault(sft), .global_fault_in(gflt),
        .drive_high_sel(dsel), .vds_high_cmp(hcmp), .vds_low_cmp(lcmp), .node_cmp(ncmp),
        .high_gate_out(hg), .low_gate_out(lg), .high_test_current_en(ht),
        .low_test_current_en(lt), .hs_active_pulldown_en(pd), .switched_pump_out(pump),
        .charge_pump_en(cpen), .vds_threshold_out(thr), .mode_out(mode));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (!bvalid) @(posedge aclk);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        r = rresp;
    endtask
    // Cycles ch0 high gate stays on
    task automatic trip(output int n);
        n = 0;
        while (!hg[0]) @(posedge aclk);
        while (hg[0]) begin
            @(posedge aclk);
            n++;
        end
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        {aresetn, awvalid, wvalid, arvalid, gflt, awaddr, araddr, wdata} = '0;
        {dsel, hcmp, lcmp, ncmp} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        wr(`HBFM_OFF_DIAG_CTRL, 32'h3f, r);
        chk({mode, r}, {`HBFM_MODE_SLEEP, `HBFM_RESP_SLVERR});
        u_mcu.wake();
        rd(`HBFM_OFF_DEV_STAT, d, r);
        chk({mode, d[0]}, {`HBFM_MODE_NORMAL, 1'b1});
        rd(8'h34, d, r);
        chk(r, `HBFM_RESP_SLVERR);
        wr(`HBFM_OFF_DIAG_CTRL, 32'h3f, r);
        repeat (2) @(posedge aclk);
        chk({ht, lt, pd}, {6'h3f, 7'h00});
        gflt <= 1'b1;
        repeat (5) @(posedge aclk);
        chk({ht, lt}, 6'h00);
        gflt <= 1'b0;
        ncmp <= 8'ha5;
        wr(`HBFM_OFF_CFG_B0, 32'h0d, r);
        rd(`HBFM_OFF_NODE_STAT, d, r);
        chk({thr[2:0], d[7:0]}, {3'h5, 8'ha5});
        dsel <= 7'h01;
        hcmp <= 7'h01;
        wr(`HBFM_OFF_MAIN_CTRL, 32'h1, r);
        trip(n);
        chk(n >= 300 && n <= 312, 1);
        wr(`HBFM_OFF_MAIN_CTRL, 32'h1, r);
        repeat (4) @(posedge aclk);
        chk(hg[0], 1'b0);
        rd(`HBFM_OFF_OVL_A, d, r);
        chk(d[0], 1'b1);
        rd(`HBFM_OFF_DEV_STAT, d, r);
        chk(d[1], 1'b1);
        wr(`HBFM_OFF_MAIN_CTRL, 32'h1, r);
        trip(n);
        chk(n >= 300 && n <= 312, 1);
        rd(`HBFM_OFF_OVL_A, d, r);
        hcmp <= 7'h00;
        rd(`HBFM_OFF_NODE_STAT, d, r);
        chk(d[7:0], 8'ha5);
        wr(`HBFM_OFF_MAIN_CTRL, 32'h1, r);
        repeat (120) @(posedge aclk);
        hcmp <= 7'h01;
        trip(n);
        chk(n >= 200 && n <= 210, 1);
        for (int i = 0; i < 2; i++) begin
            wr(`HBFM_OFF_MAIN_CTRL, 32'h2, r);
            wr(`HBFM_OFF_DIAG_CTRL, 32'h09, r);
            u_mcu.fault(i == 0, i == 1);
            chk({mode, lg, ht, lt, pump}, {`HBFM_MODE_FAILSAFE, 14'h0});
            wr(`HBFM_OFF_DIAG_CTRL, 32'h3f, r);
            chk(r, `HBFM_RESP_SLVERR);
            rd(`HBFM_OFF_OVL_A, d, r);
            chk({r, d[0]}, {`HBFM_RESP_OKAY, i == 0});
            u_mcu.fault(0, 0);
            wr(`HBFM_OFF_MAIN_CTRL, 32'h800, r);
            repeat (3) @(posedge aclk);
            rd(`HBFM_OFF_DEV_STAT, d, r);
            chk({mode, d[0]}, {`HBFM_MODE_NORMAL, 1'b1});
        end
        u_mcu.sleep();
        chk({mode, hg, lg}, 16'h0);
        complete_run();
    end
endmodule
